// ==== src/can_irq_pkg.sv ====
// constants and types for the can interrupt source block
package can_irq_pkg;
   // register offsets (word addresses on the plain register port)
   localparam logic [3:0] OFS_EVENT_FLAGS   = 4'h0; // read: flags, write 1: clear
   localparam logic [3:0] OFS_EVENT_MASK    = 4'h1; // event_irq_mask
   localparam logic [3:0] OFS_MAILBOX_MASK  = 4'h2; // mailbox_irq_mask
   localparam logic [3:0] OFS_DATA_RX       = 4'h3; // read: data_received_flags, w1c
   localparam logic [3:0] OFS_REMOTE_PEND   = 4'h4; // read: remote_pending_flags, w1c
   localparam logic [3:0] OFS_LINE_STATUS   = 4'h5; // read: request lines
   localparam logic [3:0] OFS_MODE          = 4'h6; // bit 0: test mode
   localparam logic [3:0] OFS_ERR_COUNTERS  = 4'h7; // read: tec/rec
   localparam logic [3:0] OFS_ISTAT         = 4'h8; // sticky status, read only
   localparam logic [3:0] OFS_ICLR          = 4'h9; // write one to clear status
   localparam logic [3:0] OFS_IEN           = 4'ha; // status enable

   localparam int ADDR_W  = 4;
   localparam int DATA_W  = 32;
   localparam int FLAG_W  = 16;
   localparam int MBOX_N  = 16;
   localparam int CNT_W   = 9;
   localparam int LINE_W  = 4;

   // event flag bit positions
   localparam int F_RESET_HALT_SLEEP = 0;
   localparam int F_DATA_RX_SUM      = 1;
   localparam int F_REMOTE_SUM       = 2;
   localparam int F_TX_WARN          = 3;
   localparam int F_RX_WARN          = 4;
   localparam int F_ERR_PASSIVE      = 5;
   localparam int F_BUS_OFF          = 6;
   localparam int F_OVERLOAD         = 7;
   localparam int F_OVERRUN          = 9;
   localparam int F_SLEEP_ACTIVITY   = 12;
   localparam int F_MSG_ERROR        = 13;

   // masks of which flags feed the error and status lines
   localparam logic [FLAG_W-1:0] ERROR_LINE_SET  = 16'h0078;
   localparam logic [FLAG_W-1:0] STATUS_LINE_SET = 16'h3281;
   localparam logic [FLAG_W-1:0] FLAG_RESET_VAL  = 16'h0000;
   localparam logic [FLAG_W-1:0] MASK_RESET_VAL  = 16'hffff; // all masked
   localparam logic [DATA_W-1:0] ZERO_WORD       = 32'h0000_0000;

   // error counter thresholds
   localparam logic [CNT_W-1:0] WARN_LIMIT    = 9'h060; // 96
   localparam logic [CNT_W-1:0] PASSIVE_LIMIT = 9'h080; // 128
   localparam logic [CNT_W-1:0] BUS_OFF_LIMIT = 9'h100; // 256

   // request line bit positions
   localparam int L_ERROR   = 0;
   localparam int L_STATUS  = 1;
   localparam int L_MBOX0   = 2;
   localparam int L_MBOXN   = 3;

   typedef enum logic [1:0] {
      LVL_ACTIVE  = 2'b00,
      LVL_WARN    = 2'b01,
      LVL_PASSIVE = 2'b10,
      LVL_BUS_OFF = 2'b11
   } err_level_t;

   // any bit of a masked set
   function automatic logic any_set(input logic [FLAG_W-1:0] v,
                                    input logic [FLAG_W-1:0] m);
      return |(v & ~m);
   endfunction
endpackage

// ==== src/can_irq_if.sv ====
// bundle carrying error counter level and crossings between modules
`timescale 1ns/1ps
`default_nettype none
interface can_irq_if;
   import can_irq_pkg::*;
   logic tx_warn_rise;
   logic rx_warn_rise;
   logic passive_rise;
   logic bus_off_change;
   err_level_t level;
   modport watcher (output tx_warn_rise, output rx_warn_rise, output passive_rise,
                    output bus_off_change, output level);
   modport user    (input tx_warn_rise, input rx_warn_rise, input passive_rise,
                    input bus_off_change, input level);
endinterface
`default_nettype wire

// ==== src/can_err_watch.sv ====
// error counter threshold watcher, emits one-cycle crossing pulses
`timescale 1ns/1ps
`default_nettype none
module can_err_watch
   import can_irq_pkg::*;
(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // error counters
   input  wire logic [CNT_W-1:0] tec,
   input  wire logic [CNT_W-1:0] rec,
   // crossings out
   can_irq_if.watcher            ev
);
   logic tx_warn_now;
   logic rx_warn_now;
   logic passive_now;
   logic bus_off_now;
   logic tx_warn_reg;
   logic rx_warn_reg;
   logic passive_reg;
   logic bus_off_reg;

   // threshold compares
   assign tx_warn_now = tec >= WARN_LIMIT;
   assign rx_warn_now = rec >= WARN_LIMIT;
   assign passive_now = (tec >= PASSIVE_LIMIT) || (rec >= PASSIVE_LIMIT);
   assign bus_off_now = tec >= BUS_OFF_LIMIT;

   // previous levels, so each rising crossing, and any bus off change, gives one pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_warn_reg <= 1'b0;
         rx_warn_reg <= 1'b0;
         passive_reg <= 1'b0;
         bus_off_reg <= 1'b0;
      end else begin
         tx_warn_reg <= tx_warn_now;
         rx_warn_reg <= rx_warn_now;
         passive_reg <= passive_now;
         bus_off_reg <= bus_off_now;
      end
   end

   assign ev.tx_warn_rise   = tx_warn_now & ~tx_warn_reg;
   assign ev.rx_warn_rise   = rx_warn_now & ~rx_warn_reg;
   assign ev.passive_rise   = passive_now & ~passive_reg;
   // entry into and recovery from bus off both report
   assign ev.bus_off_change = bus_off_now ^ bus_off_reg;
   assign ev.level = bus_off_now ? LVL_BUS_OFF :
                     passive_now ? LVL_PASSIVE :
                     (tx_warn_now | rx_warn_now) ? LVL_WARN : LVL_ACTIVE;

   a_bus_off_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      (tec >= BUS_OFF_LIMIT) && !$past(tec >= BUS_OFF_LIMIT) |-> ev.bus_off_change)
      else $error("bus off entry gave no pulse");
endmodule
`default_nettype wire

// ==== src/can_flag_bank.sv ====
// generic bank of sticky flags: set wins over write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module can_flag_bank
   import can_irq_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // events and clears
   input  wire logic [FLAG_W-1:0] set,
   input  wire logic [FLAG_W-1:0] clr,
   // held flags
   output logic      [FLAG_W-1:0] flags
);
   logic [FLAG_W-1:0] flags_reg;
   logic [FLAG_W-1:0] flags_next;

   // set after clear so a same-cycle event is kept
   assign flags_next = (flags_reg & ~clr) | set;
   assign flags      = flags_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) flags_reg <= FLAG_RESET_VAL;
      else        flags_reg <= flags_next;
   end
endmodule
`default_nettype wire

// ==== src/can_irq_sources.sv ====
// interrupt source aggregation for the can controller
`timescale 1ns/1ps
`default_nettype none
module can_irq_sources
   import can_irq_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic      [DATA_W-1:0] reg_rdata,
   // controller events
   input  wire logic              por_event,
   input  wire logic              halt_sleep_event,
   input  wire logic              overload_event,
   input  wire logic              overrun_event,
   input  wire logic              msg_error_event,
   input  wire logic              sleep_activity_event,
   input  wire logic [MBOX_N-1:0] data_rx_event,
   input  wire logic [MBOX_N-1:0] remote_req_event,
   input  wire logic [CNT_W-1:0]  tec,
   input  wire logic [CNT_W-1:0]  rec,
   // request lines
   output logic                   error_irq_line,
   output logic                   overload_status_irq_line,
   output logic                   mailbox_zero_irq_line,
   output logic                   other_mailbox_irq_line,
   output logic                   transfer_unit_req,
   output logic                   irq
);
   can_irq_if ev ();

   logic [FLAG_W-1:0] event_flags;
   logic [FLAG_W-1:0] event_set;
   logic [FLAG_W-1:0] event_clr;
   logic [MBOX_N-1:0] data_received_flags;
   logic [MBOX_N-1:0] remote_pending_flags;
   logic [MBOX_N-1:0] data_clr;
   logic [MBOX_N-1:0] remote_clr;
   logic [FLAG_W-1:0] event_irq_mask_reg;
   logic [MBOX_N-1:0] mailbox_irq_mask_reg;
   logic              test_mode_reg;
   logic              por_seen_reg;
   logic [LINE_W-1:0] istat;
   logic [LINE_W-1:0] istat_set;
   logic [LINE_W-1:0] istat_clr;
   logic [LINE_W-1:0] ien_reg;
   logic [LINE_W-1:0] lines;
   logic [MBOX_N-1:0] mbox_pending;
   logic [MBOX_N-1:0] mbox_active;
   logic [FLAG_W-1:0] eff_mask;
   logic [DATA_W-1:0] rdata_next;
   logic [DATA_W-1:0] rdata_reg;
   logic              reset_halt_sleep_flag;
   logic              data_frame_rx_summary_flag;
   logic              remote_request_summary_flag;
   logic              wr_flags;
   logic              wr_emask;
   logic              wr_mmask;
   logic              wr_data;
   logic              wr_remote;
   logic              wr_mode;
   logic              wr_iclr;
   logic              wr_ien;

   // threshold watcher
   can_err_watch u_watch (
      .clk   (clk),
      .rst_n (rst_n),
      .tec   (tec),
      .rec   (rec),
      .ev    (ev.watcher)
   );

   // address decode for writes
   assign wr_flags  = reg_write && (reg_addr == OFS_EVENT_FLAGS);
   assign wr_emask  = reg_write && (reg_addr == OFS_EVENT_MASK);
   assign wr_mmask  = reg_write && (reg_addr == OFS_MAILBOX_MASK);
   assign wr_data   = reg_write && (reg_addr == OFS_DATA_RX);
   assign wr_remote = reg_write && (reg_addr == OFS_REMOTE_PEND);
   assign wr_mode   = reg_write && (reg_addr == OFS_MODE);
   assign wr_iclr   = reg_write && (reg_addr == OFS_ICLR);
   assign wr_ien    = reg_write && (reg_addr == OFS_IEN);

   // per-mailbox flags
   assign data_clr   = wr_data   ? reg_wdata[MBOX_N-1:0] : '0;
   assign remote_clr = wr_remote ? reg_wdata[MBOX_N-1:0] : '0;

   can_flag_bank u_data_rx (
      .clk   (clk),
      .rst_n (rst_n),
      .set   (data_rx_event),
      .clr   (data_clr),
      .flags (data_received_flags)
   );

   can_flag_bank u_remote (
      .clk   (clk),
      .rst_n (rst_n),
      .set   (remote_req_event),
      .clr   (remote_clr),
      .flags (remote_pending_flags)
   );

   // summary flags follow the mailbox flags across all sixteen
   assign data_frame_rx_summary_flag  = |data_received_flags;
   assign remote_request_summary_flag = |remote_pending_flags;

   // event flag sets; message error ignored outside test mode
   always_comb begin
      event_set = '0;
      event_set[F_RESET_HALT_SLEEP] = por_event | halt_sleep_event;
      event_set[F_TX_WARN]          = ev.tx_warn_rise;
      event_set[F_RX_WARN]          = ev.rx_warn_rise;
      event_set[F_ERR_PASSIVE]      = ev.passive_rise;
      event_set[F_BUS_OFF]          = ev.bus_off_change;
      event_set[F_OVERLOAD]         = overload_event;
      event_set[F_OVERRUN]          = overrun_event;
      event_set[F_SLEEP_ACTIVITY]   = sleep_activity_event;
      event_set[F_MSG_ERROR]        = msg_error_event & test_mode_reg;
   end

   // summary bits are not stored, so they are never cleared here
   assign event_clr = wr_flags ? reg_wdata[FLAG_W-1:0] : '0;

   can_flag_bank u_events (
      .clk   (clk),
      .rst_n (rst_n),
      .set   (event_set),
      .clr   (event_clr),
      .flags (event_flags)
   );

   assign reset_halt_sleep_flag = event_flags[F_RESET_HALT_SLEEP];

   // power-on reset origin bypasses the mask
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         por_seen_reg <= 1'b0;
      end else if (por_event) begin
         por_seen_reg <= 1'b1;
      end else if (event_clr[F_RESET_HALT_SLEEP]) begin
         por_seen_reg <= 1'b0;
      end
   end

   // mask and mode registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         event_irq_mask_reg   <= MASK_RESET_VAL;
         mailbox_irq_mask_reg <= MASK_RESET_VAL;
         test_mode_reg        <= 1'b0;
         ien_reg              <= '0;
      end else begin
         if (wr_emask) event_irq_mask_reg   <= reg_wdata[FLAG_W-1:0];
         if (wr_mmask) mailbox_irq_mask_reg <= reg_wdata[MBOX_N-1:0];
         if (wr_mode)  test_mode_reg        <= reg_wdata[0];
         if (wr_ien)   ien_reg              <= reg_wdata[LINE_W-1:0];
      end
   end

   // effective event mask: reset flag from power-on is never masked
   always_comb begin
      eff_mask = event_irq_mask_reg;
      if (por_seen_reg) eff_mask[F_RESET_HALT_SLEEP] = 1'b0;
   end

   // mailbox gating
   assign mbox_pending = data_received_flags | remote_pending_flags;
   assign mbox_active  = mbox_pending & ~mailbox_irq_mask_reg;

   // request lines, held while any unmasked source is set
   assign lines[L_ERROR]  = any_set(event_flags & ERROR_LINE_SET, eff_mask);
   assign lines[L_STATUS] = any_set(event_flags & STATUS_LINE_SET, eff_mask);
   assign lines[L_MBOX0]  = mbox_active[0];
   assign lines[L_MBOXN]  = |mbox_active[MBOX_N-1:1];

   assign error_irq_line           = lines[L_ERROR];
   assign overload_status_irq_line = lines[L_STATUS];
   assign mailbox_zero_irq_line    = lines[L_MBOX0];
   assign other_mailbox_irq_line   = lines[L_MBOXN];
   // the transfer unit only sees the mailbox zero line
   assign transfer_unit_req        = lines[L_MBOX0];

   // sticky line status for the summary interrupt
   assign istat_set = lines;
   assign istat_clr = wr_iclr ? reg_wdata[LINE_W-1:0] : '0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) istat <= '0;
      else        istat <= (istat & ~istat_clr) | istat_set;
   end

   assign irq = |(istat & ien_reg);

   // read mux; unmapped addresses read as zero
   always_comb begin
      rdata_next = ZERO_WORD;
      if (reg_addr == OFS_EVENT_FLAGS) begin
         rdata_next[FLAG_W-1:0] = event_flags;
         rdata_next[F_DATA_RX_SUM] = data_frame_rx_summary_flag;
         rdata_next[F_REMOTE_SUM]  = remote_request_summary_flag;
      end else if (reg_addr == OFS_EVENT_MASK) begin
         rdata_next[FLAG_W-1:0] = event_irq_mask_reg;
      end else if (reg_addr == OFS_MAILBOX_MASK) begin
         rdata_next[MBOX_N-1:0] = mailbox_irq_mask_reg;
      end else if (reg_addr == OFS_DATA_RX) begin
         rdata_next[MBOX_N-1:0] = data_received_flags;
      end else if (reg_addr == OFS_REMOTE_PEND) begin
         rdata_next[MBOX_N-1:0] = remote_pending_flags;
      end else if (reg_addr == OFS_LINE_STATUS) begin
         rdata_next[LINE_W-1:0] = lines;
      end else if (reg_addr == OFS_MODE) begin
         rdata_next[0] = test_mode_reg;
      end else if (reg_addr == OFS_ERR_COUNTERS) begin
         rdata_next[CNT_W-1:0]         = tec;
         rdata_next[FLAG_W+CNT_W-1:FLAG_W] = rec;
      end else if (reg_addr == OFS_ISTAT) begin
         rdata_next[LINE_W-1:0] = istat;
      end else if (reg_addr == OFS_IEN) begin
         rdata_next[LINE_W-1:0] = ien_reg;
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)        rdata_reg <= ZERO_WORD;
      else if (reg_read) rdata_reg <= rdata_next;
      else               rdata_reg <= ZERO_WORD;
   end

   assign reg_rdata = rdata_reg;

   // checks
   sequence s_msg_err_normal;
      msg_error_event && !test_mode_reg;
   endsequence

   a_msg_err_test: assert property (@(posedge clk) disable iff (!rst_n)
      (s_msg_err_normal and !event_flags[F_MSG_ERROR]) |=> !event_flags[F_MSG_ERROR])
      else $error("message error set outside test mode");
   a_por_unmask: assert property (@(posedge clk) disable iff (!rst_n)
      por_event |=> ##1 overload_status_irq_line)
      else $error("power-on reset flag was masked");
   a_mbox_zero_line: assert property (@(posedge clk) disable iff (!rst_n)
      mailbox_zero_irq_line == (mbox_pending[0] && !mailbox_irq_mask_reg[0]))
      else $error("mailbox zero line wrong");
   a_mbox_other_line: assert property (@(posedge clk) disable iff (!rst_n)
      other_mailbox_irq_line |-> |(mbox_pending[MBOX_N-1:1] & ~mailbox_irq_mask_reg[MBOX_N-1:1]))
      else $error("other mailbox line without source");
   a_transfer_only: assert property (@(posedge clk) disable iff (!rst_n)
      transfer_unit_req == mailbox_zero_irq_line)
      else $error("transfer request from wrong line");
   a_tx_warn_flag: assert property (@(posedge clk) disable iff (!rst_n)
      ev.tx_warn_rise |=> event_flags[F_TX_WARN])
      else $error("tx warning flag not set");
   a_rx_warn_flag: assert property (@(posedge clk) disable iff (!rst_n)
      ev.rx_warn_rise |=> event_flags[F_RX_WARN])
      else $error("rx warning flag not set");
   a_passive_flag: assert property (@(posedge clk) disable iff (!rst_n)
      ((tec >= PASSIVE_LIMIT) && !$past(tec >= PASSIVE_LIMIT) && (rec < PASSIVE_LIMIT)
       && ($past(rec) < PASSIVE_LIMIT)) |=> event_flags[F_ERR_PASSIVE])
      else $error("error passive flag not set");
   a_summary_data: assert property (@(posedge clk) disable iff (!rst_n)
      data_rx_event[0] |=> data_frame_rx_summary_flag)
      else $error("data summary flag missing");
   a_mask_holds: assert property (@(posedge clk) disable iff (!rst_n)
      (event_flags[F_OVERRUN] && !eff_mask[F_OVERRUN]) |-> overload_status_irq_line)
      else $error("status line dropped with source set");

   // event to flag and flag to line checks; the error flags sit in one contiguous field
   a_bus_off_flag: assert property (@(posedge clk) disable iff (!rst_n)
      ev.bus_off_change |=> event_flags[F_BUS_OFF])
      else $error("bus off flag not set");
   a_error_line_src: assert property (@(posedge clk) disable iff (!rst_n)
      error_irq_line |-> |event_flags[F_BUS_OFF:F_TX_WARN])
      else $error("error line without error flag");
   a_msg_err_set: assert property (@(posedge clk) disable iff (!rst_n)
      (msg_error_event && test_mode_reg) |=> event_flags[F_MSG_ERROR])
      else $error("message error lost in test mode");
   a_overload_flag: assert property (@(posedge clk) disable iff (!rst_n)
      overload_event |=> event_flags[F_OVERLOAD])
      else $error("overload flag not set");
   a_mbox_masked: assert property (@(posedge clk) disable iff (!rst_n)
      mailbox_irq_mask_reg[0] |-> !mailbox_zero_irq_line)
      else $error("masked mailbox zero raised its line");
   a_remote_summary: assert property (@(posedge clk) disable iff (!rst_n)
      (|remote_req_event) |=> remote_request_summary_flag)
      else $error("remote summary flag missing");
endmodule
`default_nettype wire

// ==== bench/irq_partner.sv ====
// behavioural interrupt controller and transfer unit watching the request lines
`timescale 1ns/1ps
`default_nettype none
module irq_partner (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // request lines
   input  wire logic       transfer_unit_req,
   input  wire logic       irq,
   // observed activity
   output logic      [7:0] xfer_starts,
   output logic      [7:0] cpu_requests
);
   logic req_q;
   logic irq_q;

   // a transfer starts on each rising request; the unit never clears flags,
   // so a request that stays high is one start, not one per cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_q        <= 1'b0;
         irq_q        <= 1'b0;
         xfer_starts  <= 8'h00;
         cpu_requests <= 8'h00;
      end else begin
         req_q <= transfer_unit_req;
         irq_q <= irq;
         if (transfer_unit_req && !req_q) xfer_starts <= xfer_starts + 8'h01;
         if (irq && !irq_q) cpu_requests <= cpu_requests + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench for the can interrupt source block
`timescale 1ns/1ps
`default_nettype none
module testbench
   import can_irq_pkg::*;
;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 4'h0;
   logic [DATA_W-1:0] reg_wdata = 32'h0000_0000;
   logic              reg_write = 1'b0;
   logic              reg_read = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic [5:0]        ev = 6'h00; // por, halt, overload, overrun, msg error, sleep
   logic [MBOX_N-1:0] mb_data = 16'h0000;
   logic [MBOX_N-1:0] mb_remote = 16'h0000;
   logic [CNT_W-1:0]  tec = 9'h000;
   logic [CNT_W-1:0]  rec = 9'h000;
   logic              err_line, stat_line, mb0_line, mbn_line, xfer_req, irq;
   logic [7:0]        xfer_starts;
   logic [7:0]        cpu_reqs;
   logic [DATA_W-1:0] rd;
   logic [15:0]       m;
   int                fails = 0;
   int                total_checks = 0;
   int                cycles = 0;
   int                ev_idx [5] = '{1, 2, 3, 5, 4};
   int                fbit [5] = '{0, 7, 9, 12, 13};

   always #5 clk = ~clk;

   can_irq_sources i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .por_event(ev[0]), .halt_sleep_event(ev[1]),
      .overload_event(ev[2]), .overrun_event(ev[3]), .msg_error_event(ev[4]),
      .sleep_activity_event(ev[5]), .data_rx_event(mb_data),
      .remote_req_event(mb_remote), .tec(tec), .rec(rec), .error_irq_line(err_line),
      .overload_status_irq_line(stat_line), .mailbox_zero_irq_line(mb0_line),
      .other_mailbox_irq_line(mbn_line), .transfer_unit_req(xfer_req), .irq(irq));

   irq_partner i_partner (.clk(clk), .rst_n(rst_n), .transfer_unit_req(xfer_req),
      .irq(irq), .xfer_starts(xfer_starts), .cpu_requests(cpu_reqs));

   task automatic give_verdict();
      if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // a hang counts as a mismatch and ends the run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         give_verdict();
      end
   end

   task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask

   // one-cycle strobes; effects are sampled 1 ns after the edge that takes them
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
      #1;
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      chk_word(reg_rdata, exp);
   endtask

   task automatic pulse_ev(input int k);
      @(posedge clk);
      ev[k] <= 1'b1;
      @(posedge clk);
      ev <= 6'h00;
      #1;
   endtask

   task automatic pulse_mb(input logic [MBOX_N-1:0] d, input logic [MBOX_N-1:0] r);
      @(posedge clk);
      mb_data   <= d;
      mb_remote <= r;
      @(posedge clk);
      mb_data   <= 16'h0000;
      mb_remote <= 16'h0000;
      #1;
   endtask

   // counters are levels; allow the watcher a few edges to see the crossing
   task automatic set_cnt(input logic [CNT_W-1:0] t, input logic [CNT_W-1:0] r);
      @(posedge clk);
      tec <= t;
      rec <= r;
      repeat (3) @(posedge clk);
      #1;
   endtask

   initial begin
      repeat (20) @(posedge clk);
      #1;
      chk_bit(stat_line, 1'b0);
      @(posedge clk);
      rst_n <= 1'b1;
      #1;
      rd_chk(OFS_EVENT_FLAGS, 32'h0000_0000);
      rd_chk(OFS_EVENT_MASK, 32'h0000_ffff);
      rd_chk(OFS_MAILBOX_MASK, 32'h0000_ffff);
      wr(4'hf, 32'hffff_ffff);
      rd_chk(4'hf, 32'h0000_0000);
      // power-on flag passes the mask, halt/sleep does not
      pulse_ev(0);
      chk_bit(stat_line, 1'b1);
      wr(OFS_EVENT_FLAGS, 32'h0000_0001);
      chk_bit(stat_line, 1'b0);
      pulse_ev(1);
      rd_chk(OFS_EVENT_FLAGS, 32'h0000_0001);
      chk_bit(stat_line, 1'b0);
      wr(OFS_EVENT_FLAGS, 32'h0000_ffff);
      // message error is refused outside test mode
      wr(OFS_EVENT_MASK, 32'h0000_0000);
      pulse_ev(4);
      rd_chk(OFS_EVENT_FLAGS, 32'h0000_0000);
      wr(OFS_MODE, 32'h0000_0001);
      // each status source, unmasked then masked
      for (int p = 0; p < 2; p++) begin
         wr(OFS_EVENT_MASK, p ? 32'h0000_ffff : 32'h0000_0000);
         for (int i = 0; i < 5; i++) begin
            pulse_ev(ev_idx[i]);
            rd_chk(OFS_EVENT_FLAGS, 32'h1 << fbit[i]);
            chk_bit(stat_line, p == 0);
            chk_bit(err_line, 1'b0);
            wr(OFS_EVENT_FLAGS, 32'h1 << fbit[i]);
            chk_bit(stat_line, 1'b0);
         end
      end
      wr(OFS_MODE, 32'h0000_0000);
      // error counter thresholds, each crossing its own flag
      wr(OFS_EVENT_MASK, 32'h0000_0000);
      set_cnt(9'h05f, 9'h05f);
      rd_chk(OFS_EVENT_FLAGS, 32'h0000_0000);
      chk_bit(err_line, 1'b0);
      set_cnt(9'h05f, 9'h060);
      rd_chk(OFS_EVENT_FLAGS, 32'h0000_0010);
      chk_bit(err_line, 1'b1);
      set_cnt(9'h060, 9'h060);
      rd_chk(OFS_EVENT_FLAGS, 32'h0000_0018);
      set_cnt(9'h080, 9'h060);
      rd_chk(OFS_EVENT_FLAGS, 32'h0000_0038);
      set_cnt(9'h100, 9'h060);
      rd_chk(OFS_EVENT_FLAGS, 32'h0000_0078);
      rd_chk(OFS_ERR_COUNTERS, 32'h0060_0100);
      wr(OFS_EVENT_FLAGS, 32'h0000_0078);
      chk_bit(err_line, 1'b0);
      set_cnt(9'h064, 9'h000);
      rd_chk(OFS_EVENT_FLAGS, 32'h0000_0040);
      chk_bit(err_line, 1'b1);
      wr(OFS_EVENT_FLAGS, 32'h0000_ffff);
      set_cnt(9'h000, 9'h080);
      rd_chk(OFS_EVENT_FLAGS, 32'h0000_0030);
      wr(OFS_EVENT_FLAGS, 32'h0000_ffff);
      // mailbox zero: data and remote, both reach the transfer unit
      wr(OFS_MAILBOX_MASK, 32'h0000_0000);
      pulse_mb(16'h0001, 16'h0000);
      chk_bit(mb0_line, 1'b1);
      chk_bit(xfer_req, 1'b1);
      chk_bit(mbn_line, 1'b0);
      rd_chk(OFS_DATA_RX, 32'h0000_0001);
      rd_chk(OFS_EVENT_FLAGS, 32'h0000_0002);
      wr(OFS_DATA_RX, 32'h0000_0001);
      chk_bit(mb0_line, 1'b0);
      rd_chk(OFS_EVENT_FLAGS, 32'h0000_0000);
      pulse_mb(16'h0000, 16'h0001);
      chk_bit(mb0_line, 1'b1);
      rd_chk(OFS_EVENT_FLAGS, 32'h0000_0004);
      wr(OFS_REMOTE_PEND, 32'h0000_0001);
      // every other mailbox only on the second line, never the transfer unit
      for (int k = 1; k < MBOX_N; k++) begin
         m = 16'h0001 << k;
         if (k % 2 == 1) pulse_mb(16'h0000, m);
         else pulse_mb(m, 16'h0000);
         chk_bit(mbn_line, 1'b1);
         chk_bit(mb0_line, 1'b0);
         chk_bit(xfer_req, 1'b0);
         wr(OFS_DATA_RX, {16'h0000, m});
         wr(OFS_REMOTE_PEND, {16'h0000, m});
         chk_bit(mbn_line, 1'b0);
      end
      // masked mailbox holds its flag; unmasking raises the line
      wr(OFS_MAILBOX_MASK, 32'h0000_0001);
      pulse_mb(16'h0001, 16'h0000);
      chk_bit(mb0_line, 1'b0);
      rd_chk(OFS_DATA_RX, 32'h0000_0001);
      wr(OFS_MAILBOX_MASK, 32'h0000_0000);
      chk_bit(mb0_line, 1'b1);
      wr(OFS_DATA_RX, 32'h0000_0001);
      chk_word({24'h0, xfer_starts}, 32'h0000_0003);
      // sticky status, enable and clear of the summary interrupt
      wr(OFS_ICLR, 32'h0000_000f);
      pulse_ev(3);
      @(posedge clk);
      #1;
      rd_chk(OFS_ISTAT, 32'h0000_0002);
      rd_chk(OFS_LINE_STATUS, 32'h0000_0002);
      chk_bit(irq, 1'b0);
      wr(OFS_IEN, 32'h0000_0002);
      chk_bit(irq, 1'b1);
      wr(OFS_EVENT_FLAGS, 32'h0000_0200);
      chk_bit(irq, 1'b1);
      wr(OFS_ICLR, 32'h0000_0002);
      chk_bit(irq, 1'b0);
      // the summary interrupt rose only once, when its enable was written
      chk_word({24'h0, cpu_reqs}, 32'h0000_0001);
      give_verdict();
   end
endmodule
`default_nettype wire
